// File: hdl/rcw_pkg.sv
// Constants and types shared by the reset controller and its watchdog counters.
// Assumes a single 40 MHz system clock for every file that uses it.
package rcw_pkg;

  // System clock period and the reset stretch applied after the last source goes away.
  localparam int CLK_PERIOD_NS  = 25;
  localparam int RST_STRETCH_NS = 1000;
  localparam int RST_STRETCH_CYC =
    (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths of the two watchdog counters and of the cause vector.
  localparam int SW_WDOG_W  = 32;
  localparam int BKP_WDOG_W = 16;
  localparam int NUM_SRC    = 7;

  // Cause positions, lowest index has the highest priority.
  localparam int SRC_POR  = 0;
  localparam int SRC_EXT  = 1;
  localparam int SRC_LVD  = 2;
  localparam int SRC_PLL  = 3;
  localparam int SRC_JTAG = 4;
  localparam int SRC_WDOG = 5;
  localparam int SRC_SOFT = 6;

  // Cause vector after a power-up reset, and the cleared status value.
  localparam logic [6:0] CAUSE_POR_VAL   = 7'h01;
  localparam logic [6:0] CAUSE_CLEAR_VAL = 7'h00;

  // Backup watchdog clock selection codes.
  localparam logic BKP_SEL_SYS   = 1'b0;
  localparam logic BKP_SEL_RELAX = 1'b1;

  // Reset sequencer states, Gray coded along run, hold, stretch.
  typedef enum logic [1:0] {
    RCW_RUN     = 2'b00,
    RCW_HOLD    = 2'b01,
    RCW_STRETCH = 2'b11
  } rcw_state_t;

endpackage : rcw_pkg

// File: hdl/rcw_wdt_if.sv
// Connection between the reset controller and one watchdog down-counter.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface rcw_wdt_if #(
  parameter int W = 32
);
  logic         tick;
  logic         restart;
  logic         en;
  logic [W-1:0] load;
  logic [W-1:0] count;
  logic         underflow;

  // The controller drives the count controls and watches the underflow.
  modport ctrl (output tick, output restart, output en, output load,
                input count, input underflow);
  // The counter takes the controls and reports its state.
  modport cnt  (input tick, input restart, input en, input load,
                output count, output underflow);
endinterface : rcw_wdt_if

// File: hdl/rcw_wdog.sv
// Free-running watchdog down-counter with reload and an underflow pulse.
// Assumes tick, restart and load come from logic on the same clock.
`timescale 1ns/100ps
module rcw_wdog (
  input  wire logic ref_clk,
  input  wire logic rstn,
  rcw_wdt_if.cnt    wd
);

  // Reload on restart or while disabled, otherwise count down once per tick.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wd.count     <= '1;
      wd.underflow <= 1'b0;
    end else if (wd.restart || !wd.en) begin
      wd.count     <= wd.load;
      wd.underflow <= 1'b0;
    end else if (wd.tick) begin
      if (wd.count == '0) begin
        wd.count     <= wd.load;
        wd.underflow <= 1'b1;
      end else begin
        wd.count     <= wd.count - 1'b1;
        wd.underflow <= 1'b0;
      end
    end else begin
      wd.underflow <= 1'b0;
    end
  end

  // A tick on a nonzero count must lower it by exactly one.
  property p_wdog_dec;
    @(posedge ref_clk) disable iff (!rstn)
      (wd.en && !wd.restart && wd.tick && wd.count != '0)
        |=> wd.count == $past(wd.count) - 1'b1;
  endproperty
  a_wdog_dec: assert property (p_wdog_dec) else $error("watchdog did not count down");

  // Underflow is raised only right after a tick at zero.
  property p_wdog_uf;
    @(posedge ref_clk) disable iff (!rstn)
      wd.underflow |-> $past(wd.tick) && $past(wd.count) == '0 && wd.count == $past(wd.load);
  endproperty
  a_wdog_uf: assert property (p_wdog_uf) else $error("watchdog underflow without zero");

endmodule : rcw_wdog

// File: hdl/rcw_reset_ctrl.sv
// Chip reset controller: gathers seven reset causes, drives the internal
// reset and the reset-out pin, records the last cause, hosts two watchdogs.
// Assumes pin-level sources are asynchronous to ref_clk; software controls
// arrive from logic on ref_clk.
`timescale 1ns/100ps

module rcw_reset_ctrl #(
  parameter int SW_W  = rcw_pkg::SW_WDOG_W,
  parameter int BKP_W = rcw_pkg::BKP_WDOG_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             reset_in_pin_n,
  input  wire logic             por_det,
  input  wire logic             pll_loss,
  input  wire logic             low_voltage_detector,
  input  wire logic             jtag_rst,
  input  wire logic             relaxation_oscillator,
  input  wire logic             sw_rst_req,
  input  wire logic             rst_out_assert,
  input  wire logic             lvd_reset_en,
  input  wire logic             lvd_int_en,
  input  wire logic             sw_wdog_en,
  input  wire logic             sw_wdog_restart,
  input  wire logic [SW_W-1:0]  sw_wdog_load,
  input  wire logic             backup_watchdog_en,
  input  wire logic             backup_watchdog_restart,
  input  wire logic [BKP_W-1:0] backup_watchdog_load,
  input  wire logic             backup_watchdog_clk_sel,
  output logic                  sys_rst_n,
  output logic                  reset_out_pin_n,
  output logic [6:0]            reset_cause,
  output logic                  lvd_irq
);

  localparam logic [7:0] STRETCH_LAST = 8'(rcw_pkg::RST_STRETCH_CYC - 1);

  logic [5:0]               sync1_reg;
  logic [5:0]               sync2_reg;
  logic                     osc_prev_reg;
  logic                     bkp_tick_reg;
  logic [6:0]               src;
  logic                     level_active;
  logic [6:0]               pick;
  rcw_pkg::rcw_state_t      state_reg;
  logic [7:0]               stretch_reg;
  logic [6:0]               pend_reg;
  logic                     sys_rst_n_reg;
  logic                     reset_out_pin_n_reg;
  logic [6:0]               cause_reg;
  logic                     lvd_irq_reg;

  rcw_wdt_if #(.W(SW_W))  sw_if ();
  rcw_wdt_if #(.W(BKP_W)) bkp_if ();

  // Two-stage synchronisers for every pin-level input; the pin is inverted
  // after the second stage so the first stage feeds nothing else.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {relaxation_oscillator, jtag_rst, low_voltage_detector,
                    pll_loss, por_det, reset_in_pin_n};
      sync2_reg <= sync1_reg;
    end
  end

  // Backup watchdog tick: every clock, or each rising oscillator edge.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      osc_prev_reg <= 1'b0;
      bkp_tick_reg <= 1'b0;
    end else begin
      osc_prev_reg <= sync2_reg[5];
      if (backup_watchdog_clk_sel == rcw_pkg::BKP_SEL_RELAX) begin
        bkp_tick_reg <= sync2_reg[5] && !osc_prev_reg;
      end else begin
        bkp_tick_reg <= 1'b1;
      end
    end
  end

  // Watchdogs are held reloaded while the system is in reset.
  assign sw_if.tick     = 1'b1;
  assign sw_if.restart  = sw_wdog_restart || !sys_rst_n_reg;
  assign sw_if.en       = sw_wdog_en;
  assign sw_if.load     = sw_wdog_load;
  assign bkp_if.tick    = bkp_tick_reg;
  assign bkp_if.restart = backup_watchdog_restart || !sys_rst_n_reg;
  assign bkp_if.en      = backup_watchdog_en;
  assign bkp_if.load    = backup_watchdog_load;

  rcw_wdog u_sw_wdog (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wd      (sw_if.cnt)
  );

  rcw_wdog u_bkp_wdog (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .wd      (bkp_if.cnt)
  );

  // Cause vector; the detector only resets when its reset enable is set.
  always_comb begin
    src                    = 7'h00;
    src[rcw_pkg::SRC_POR]  = sync2_reg[1];
    src[rcw_pkg::SRC_EXT]  = !sync2_reg[0];
    src[rcw_pkg::SRC_LVD]  = sync2_reg[3] && lvd_reset_en;
    src[rcw_pkg::SRC_PLL]  = sync2_reg[2];
    src[rcw_pkg::SRC_JTAG] = sync2_reg[4];
    src[rcw_pkg::SRC_WDOG] = sw_if.underflow || bkp_if.underflow;
    src[rcw_pkg::SRC_SOFT] = sw_rst_req;
    level_active = |src[rcw_pkg::SRC_JTAG:rcw_pkg::SRC_POR];
  end

  // Fixed priority: the lowest set index wins.
  always_comb begin
    pick = 7'h00;
    for (int i = rcw_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (src[i]) begin
        pick = 7'h00;
        pick[i] = 1'b1;
      end
    end
  end

  // Sequencer: hold while level sources stand, then stretch, then release.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= rcw_pkg::RCW_HOLD;
      stretch_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        rcw_pkg::RCW_RUN: begin
          if (|src) begin
            state_reg <= rcw_pkg::RCW_HOLD;
          end
        end
        rcw_pkg::RCW_HOLD: begin
          if (!level_active) begin
            state_reg   <= rcw_pkg::RCW_STRETCH;
            stretch_reg <= STRETCH_LAST;
          end
        end
        rcw_pkg::RCW_STRETCH: begin
          if (level_active) begin
            state_reg <= rcw_pkg::RCW_HOLD;
          end else if (stretch_reg == 8'h00) begin
            state_reg <= rcw_pkg::RCW_RUN;
          end else begin
            stretch_reg <= stretch_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= rcw_pkg::RCW_HOLD;
        end
      endcase
    end
  end

  // Pending cause is caught on entry to reset and published at release.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg  <= rcw_pkg::CAUSE_POR_VAL;
      cause_reg <= rcw_pkg::CAUSE_CLEAR_VAL;
    end else begin
      if (state_reg == rcw_pkg::RCW_RUN && |src) begin
        pend_reg <= pick;
      end
      if (state_reg == rcw_pkg::RCW_STRETCH && !level_active && stretch_reg == 8'h00) begin
        cause_reg <= pend_reg;
      end
    end
  end

  // Outputs: internal reset, reset-out pin, detector interrupt.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sys_rst_n_reg       <= 1'b0;
      reset_out_pin_n_reg <= 1'b0;
      lvd_irq_reg         <= 1'b0;
    end else begin
      sys_rst_n_reg       <= (state_reg == rcw_pkg::RCW_RUN);
      reset_out_pin_n_reg <= (state_reg == rcw_pkg::RCW_RUN) && !rst_out_assert;
      lvd_irq_reg         <= sync2_reg[3] && lvd_int_en;
    end
  end

  assign sys_rst_n       = sys_rst_n_reg;
  assign reset_out_pin_n = reset_out_pin_n_reg;
  assign reset_cause     = cause_reg;
  assign lvd_irq         = lvd_irq_reg;

  // Any source while running takes the system into reset two cycles later.
  property p_src_resets;
    @(posedge ref_clk) disable iff (!rstn)
      (state_reg == rcw_pkg::RCW_RUN && |src) |=> ##1 !sys_rst_n_reg;
  endproperty
  a_src_resets: assert property (p_src_resets) else $error("source did not reset chip");

  // The reset-out pin follows the internal reset as well.
  property p_out_follows;
    @(posedge ref_clk) disable iff (!rstn)
      !sys_rst_n_reg |-> !reset_out_pin_n_reg;
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("reset out not asserted");

  // Status flags change only on the release cycle.
  property p_cause_at_release;
    @(posedge ref_clk) disable iff (!rstn)
      $changed(cause_reg) |-> $rose(state_reg == rcw_pkg::RCW_RUN) ##1 $rose(sys_rst_n_reg);
  endproperty
  a_cause_at_release: assert property (p_cause_at_release) else $error("cause changed early");

  // At most one cause flag is ever shown.
  property p_cause_onehot;
    @(posedge ref_clk) disable iff (!rstn)
      $onehot0(cause_reg);
  endproperty
  a_cause_onehot: assert property (p_cause_onehot) else $error("several cause flags set");

  // The software bit drives the reset-out pin low on the next edge.
  property p_sw_rst_out;
    @(posedge ref_clk) disable iff (!rstn)
      rst_out_assert |=> !reset_out_pin_n_reg;
  endproperty
  a_sw_rst_out: assert property (p_sw_rst_out) else $error("reset out ignored software bit");

  // A press on the reset-in pin while running drives the separate reset-out pin low.
  property p_pins_distinct;
    @(posedge ref_clk) disable iff (!rstn)
      (state_reg == rcw_pkg::RCW_RUN && !sync2_reg[0]) |=> ##1 !reset_out_pin_n_reg;
  endproperty
  a_pins_distinct: assert property (p_pins_distinct) else $error("reset out missed reset in");

  // The detector interrupt follows its enable.
  property p_lvd_irq;
    @(posedge ref_clk) disable iff (!rstn)
      (sync2_reg[3] && lvd_int_en) |=> lvd_irq_reg;
  endproperty
  a_lvd_irq: assert property (p_lvd_irq) else $error("detector interrupt missing");

  // A software watchdog underflow while running leads into reset.
  property p_sw_wdog_reset;
    @(posedge ref_clk) disable iff (!rstn)
      (sw_if.underflow && state_reg == rcw_pkg::RCW_RUN) |=> state_reg == rcw_pkg::RCW_HOLD;
  endproperty
  a_sw_wdog_reset: assert property (p_sw_wdog_reset) else $error("watchdog did not reset");

  // With the system clock selected the backup watchdog ticks every cycle.
  property p_bkp_sys_tick;
    @(posedge ref_clk) disable iff (!rstn)
      (backup_watchdog_clk_sel == rcw_pkg::BKP_SEL_SYS) |=> bkp_tick_reg;
  endproperty
  a_bkp_sys_tick: assert property (p_bkp_sys_tick) else $error("backup tick missing");

  // Main scenarios.
  c_release:  cover property (@(posedge ref_clk) disable iff (!rstn) $rose(sys_rst_n_reg));
  c_wdog_rst: cover property (@(posedge ref_clk) disable iff (!rstn)
                              bkp_if.underflow && state_reg == rcw_pkg::RCW_RUN);
  c_soft_rst: cover property (@(posedge ref_clk) disable iff (!rstn)
                              cause_reg[rcw_pkg::SRC_SOFT]);

endmodule : rcw_reset_ctrl

// File: verif/rcw_board_model.sv
// Board-side model: a reset switch on the reset-in pin and board logic on reset-out.
// Assumes it shares ref_clk with the controller; press is a one-cycle request.
`timescale 1ns/100ps
module rcw_board_model (
  ref_clk,
  press,
  press_len,
  reset_out_pin_n,
  reset_in_pin_n,
  out_low_cnt
);
  input  wire logic        ref_clk;
  input  wire logic        press;
  input  wire logic [15:0] press_len;
  input  wire logic        reset_out_pin_n;
  output wire logic        reset_in_pin_n;
  output logic      [15:0] out_low_cnt;

  logic [15:0] hold_reg;

  // The switch holds the pin low for press_len cycles, short or long.
  initial hold_reg = 16'h0;
  always @(posedge ref_clk) begin
    if (press) begin
      hold_reg <= press_len;
    end else if (hold_reg != 16'h0) begin
      hold_reg <= hold_reg - 16'h1;
    end
  end

  // The pin has a pull-up, so a released switch reads high.
  assign reset_in_pin_n = (hold_reg == 16'h0);

  // Board logic counts the cycles it is held in reset by the reset-out pin.
  initial out_low_cnt = 16'h0;
  always @(posedge ref_clk) begin
    if (reset_out_pin_n == 1'b0) begin
      out_low_cnt <= out_low_cnt + 16'h1;
    end
  end
endmodule : rcw_board_model

// File: verif/rcw_reset_ctrl_tb.sv
// Self-checking bench for the reset controller; each scenario after power-up is one task.
// Assumes a 40 MHz ref_clk and the board model on the two reset pins.
`timescale 1ns/100ps
module rcw_reset_ctrl_tb;
  logic        ref_clk, rstn, rst_pin_n, press, osc, sw_req, out_assert;
  logic        lvd_rst_en, lvd_int_en, sw_en, sw_restart, bk_en, bk_restart, bk_sel;
  logic        sys_rst_n, rst_out_n, lvd_irq;
  logic [15:0] press_len, out_low_cnt, bk_load;
  logic [31:0] sw_load;
  logic [6:0]  src, cause;
  int          fail_count, n_compared, n0, n1, k;

  // System clock at 25 ns and a free-running 5 MHz relaxation oscillator.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    osc = 1'b0;
    forever #100 osc = ~osc;
  end

  rcw_reset_ctrl dut (
    .ref_clk(ref_clk), .rstn(rstn), .reset_in_pin_n(rst_pin_n), .por_det(src[0]),
    .pll_loss(src[3]), .low_voltage_detector(src[2]), .jtag_rst(src[4]),
    .relaxation_oscillator(osc), .sw_rst_req(sw_req), .rst_out_assert(out_assert),
    .lvd_reset_en(lvd_rst_en), .lvd_int_en(lvd_int_en), .sw_wdog_en(sw_en),
    .sw_wdog_restart(sw_restart), .sw_wdog_load(sw_load), .backup_watchdog_en(bk_en),
    .backup_watchdog_restart(bk_restart), .backup_watchdog_load(bk_load),
    .backup_watchdog_clk_sel(bk_sel), .sys_rst_n(sys_rst_n),
    .reset_out_pin_n(rst_out_n), .reset_cause(cause), .lvd_irq(lvd_irq));

  rcw_board_model board (
    .ref_clk(ref_clk), .press(press), .press_len(press_len),
    .reset_out_pin_n(rst_out_n), .reset_in_pin_n(rst_pin_n), .out_low_cnt(out_low_cnt));

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Compares one seen value with its expected value.
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits, under a bound, for the internal reset to reach a level.
  task automatic wait_rst(input logic val, input int bound, output int n);
    for (n = 0; n < bound && sys_rst_n !== val; n++) @(negedge ref_clk);
    if (sys_rst_n !== val) begin
      fail_count++;
      $display("mismatch at %0t: reset wait ran out", $time);
      end_sim();
    end
  endtask : wait_rst

  // Waits for a reset, drops the level sources and both watchdog enables, waits for release and checks the cause.
  task automatic finish_rst(input logic [6:0] exp, output int n);
    int m;
    wait_rst(1'b0, 300, n);
    src = 7'h00;
    sw_en = 1'b0;
    bk_en = 1'b0;
    wait_rst(1'b1, 300, m);
    @(negedge ref_clk);
    check(cause, exp);
  endtask : finish_rst

  // Level sources one by one, the reset-in pin short and long, software, priority.
  task automatic t_sources;
    for (k = 0; k < 5; k++) begin
      if (k != 1) begin
        @(negedge ref_clk) src[k] = 1'b1;
        finish_rst(7'h01 << k, n0);
      end
    end
    for (k = 3; k < 100; k += 57) begin
      @(negedge ref_clk) press = 1'b1;
      press_len = 16'(k);
      @(negedge ref_clk) press = 1'b0;
      finish_rst(7'h02, n0);
    end
    @(negedge ref_clk) sw_req = 1'b1;
    @(negedge ref_clk) sw_req = 1'b0;
    finish_rst(7'h40, n0);
    @(negedge ref_clk) src = 7'h18;
    finish_rst(7'h08, n0);
  endtask : t_sources

  // Software drives reset-out alone; the board sees exactly the held cycles.
  task automatic t_out_pin;
    logic [15:0] c0;
    @(negedge ref_clk) out_assert = 1'b1;
    c0 = out_low_cnt;
    repeat (10) @(negedge ref_clk);
    check({6'h0, rst_out_n}, 7'h00);
    check({6'h0, sys_rst_n}, 7'h01);
    out_assert = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(7'(out_low_cnt - c0), 7'd10);
    check({6'h0, rst_out_n}, 7'h01);
  endtask : t_out_pin

  // Detector raises the interrupt only when allowed, and no reset when barred.
  task automatic t_lvd;
    @(negedge ref_clk) lvd_rst_en = 1'b0;
    src[2] = 1'b1;
    repeat (6) @(negedge ref_clk);
    check({5'h0, lvd_irq, sys_rst_n}, 7'h03);
    lvd_int_en = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({6'h0, lvd_irq}, 7'h00);
    // Let the synchroniser drain before the detector may reset the chip again.
    src[2] = 1'b0;
    repeat (4) @(negedge ref_clk);
    lvd_rst_en = 1'b1;
    lvd_int_en = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({5'h0, lvd_irq, sys_rst_n}, 7'h01);
  endtask : t_lvd

  // Software watchdog kept alive by restarts, then left to underflow.
  task automatic t_sw_wdog;
    int lows;
    lows = 0;
    @(negedge ref_clk) sw_load = 32'h10;
    sw_en = 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge ref_clk) sw_restart = (k % 8 == 0);
      lows += (sys_rst_n !== 1'b1);
    end
    check(7'(lows), 7'h00);
    finish_rst(7'h20, n0);
  endtask : t_sw_wdog

  // Backup watchdog on each clock choice; the oscillator runs it far slower.
  task automatic t_bk_wdog;
    @(negedge ref_clk) bk_load = 16'h3;
    bk_sel = 1'b0;
    bk_en = 1'b1;
    finish_rst(7'h20, n0);
    @(negedge ref_clk) bk_sel = 1'b1;
    bk_en = 1'b1;
    finish_rst(7'h20, n1);
    check(((n1 > n0 + 16) ? 7'h01 : 7'h00), 7'h01);
  endtask : t_bk_wdog

  // Main sequence: power-up reset, then every scenario in turn.
  initial begin
    rstn = 1'b0;
    press = 1'b0;
    press_len = 16'h0;
    src = 7'h00;
    {sw_req, out_assert, sw_en, sw_restart, bk_en, bk_restart, bk_sel} = 7'h00;
    {lvd_rst_en, lvd_int_en} = 2'b11;
    sw_load = 32'h10;
    bk_load = 16'h3;
    fail_count = 0;
    n_compared = 0;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    wait_rst(1'b1, 200, n0);
    // Release takes the stretch plus two sync, one entry and one output edge.
    check(7'(n0), 7'(rcw_pkg::RST_STRETCH_CYC + 4));
    @(negedge ref_clk);
    check(cause, 7'h01);
    check({6'h0, rst_out_n}, 7'h01);
    $display("test power_up done");
    t_sources();
    $display("test sources done");
    t_out_pin();
    $display("test out_pin done");
    t_lvd();
    $display("test lvd done");
    t_sw_wdog();
    $display("test sw_wdog done");
    t_bk_wdog();
    $display("test bk_wdog done");
    end_sim();
  end
endmodule : rcw_reset_ctrl_tb
